/* File: rtl/uacs_pkg.sv */
package uacs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_MAP    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IST    = 8'h0C;
  localparam logic [7:0] ADDR_IMASK  = 8'h10;

  // control field positions
  localparam int CTRL_BCD_EN    = 0;
  localparam int CTRL_SENSE_SEL = 1;
  localparam int CTRL_WAKE_EN   = 2;

  // charger code map field positions (two bits each)
  localparam int MAP_UNCONF  = 0;
  localparam int MAP_SDP     = 2;
  localparam int MAP_CHARGE  = 4;
  localparam int MAP_SUSPEND = 6;

  // interrupt bit positions
  localparam int EV_ATTACH = 0;
  localparam int EV_DETACH = 1;
  localparam int EV_CHG    = 2;
  localparam int EV_WAKE   = 3;

  // reset values
  localparam logic [2:0] CTRL_RST  = 3'h5;
  localparam logic [7:0] MAP_RST   = 8'hE4;
  localparam logic [3:0] IMASK_RST = 4'h0;

  // vbus debounce time
  localparam int         CLK_MHZ    = 50;
  localparam int         DEB_NS     = 1000;
  localparam logic [5:0] DEB_CYC    = 6'((DEB_NS * CLK_MHZ + 999) / 1000);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CHG_NONE, CHG_SDP, CHG_CDP, CHG_DCP} uacs_chg_e;
  typedef enum logic [1:0] {BCD_IDLE, BCD_DETECT, BCD_DONE} uacs_bcd_e;

  typedef struct packed {
    logic suspended;
    logic configured;
    logic rx_active;
    logic tx_active;
  } uacs_usb_s;

  typedef struct packed {
    logic dplus_line;
    logic charger_type_bit0;
    logic charger_type_bit1;
    logic suspend_ind;
    logic rx_activity_led_n;
    logic tx_activity_led_n;
    logic power_cut;
    logic transceiver_drive_enable;
    logic remote_wakeup_req;
    logic bcd_start;
  } uacs_pins_s;

  typedef struct packed {
    logic [1:0]  vsync;
    logic        vstable;
    logic [5:0]  deb_cnt;
    logic        wake_d;
    uacs_bcd_e   bcd;
    uacs_chg_e   chg;
    logic [2:0]  ctrl;
    logic [7:0]  map;
    logic [3:0]  ist;
    logic [3:0]  imask;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] hrdata;
    logic        irq;
    uacs_pins_s  pins;
    logic        pin_oe_n;
  } uacs_st_s;

endpackage

/* File: rtl/uacs_top.sv */
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none

module uacs_top
  import uacs_pkg::*;
(
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [7:0]           haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // sense inputs and usb core state
  input  wire logic                 vbus_pin,
  input  wire logic                 vbus_sense_input,
  input  wire uacs_pkg::uacs_usb_s  usb,
  input  wire logic                 chg_done,
  input  wire uacs_pkg::uacs_chg_e  chg_type,
  input  wire logic                 uart_tx_pending,
  input  wire logic                 wakeup_in,
  // pins toward the board and usb core
  output var  uacs_pkg::uacs_pins_s pins,
  output logic                      pin_oe_n,
  output logic                      irq
);
  import uacs_pkg::*;

  uacs_st_s st;
  uacs_st_s next_st;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  // ADDR_CTRL: control, read/write
  //   bit 0: charger detection enable
  //   bit 1: sense source, 1 picks the bus-detect gpio
  //   bit 2: remote wakeup enable
  // ADDR_MAP: charger code map, read/write
  //   bits 1:0 no vbus or no result yet
  //   bits 3:2 standard port
  //   bits 5:4 charging or dedicated port
  //   bits 7:6 suspended
  // ADDR_STATUS: status, read only
  //   bits 1:0 detection state
  //   bit 2: debounced vbus
  //   bit 3: pull-up enable
  //   bits 5:4 charger type
  //   bit 6: usb suspended
  //   bit 7: usb configured
  // ADDR_IST: event status, write one to clear
  //   bit 0: attach, bit 1: detach
  //   bit 2: charger found, bit 3: wakeup
  // ADDR_IMASK: event mask, same layout, 1 enables
  // every register sits in the low bits of a word, the rest read zero
  // unmapped offsets read zero, writes to them are dropped
  // hsize is ignored, only whole-word transfers are expected

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  // two sync flops, then the debounce count, then one pin register:
  // a vbus change shows on the pins about 53 cycles later
  // a glitch shorter than the debounce time never reaches the pins
  // detection starts one cycle after vbus counts as present
  // the detector answer is taken only while detecting
  // a late answer after vbus loss is ignored, the sequence is idle
  // the pull-up and charger code follow the result one cycle later
  // with detection enabled a dedicated charger never gets the pull-up, it cannot enumerate
  // all pin outputs are registered, so each lags its cause by one cycle
  // the bus has no wait states; read data is a snapshot taken in the
  // address phase, so a read right after a write shows the old value
  // limitation: the block only requests remote wakeup; the resume
  // signalling itself belongs to the usb core
  // trade-off: one shared output enable for all pins keeps the pad
  // control simple, but no pin can be released on its own

  // ------------------------------------------------------------------
  // interrupt
  // ------------------------------------------------------------------
  // each event sets its status bit and it stays set until cleared
  // a clear and a new event in one cycle: the event wins, none is lost
  // irq is a level, high while any unmasked status bit is set
  // irq is taken from the next status value, so it moves with the bits
  // the mask resets to zero, so irq stays low until software opts in

  // ------------------------------------------------------------------
  // charger code
  // ------------------------------------------------------------------
  // priority: no vbus or no result, then suspend, then port type
  // without detection enabled the type stays none and the code
  // shows the no-result entry while the pull-up follows vbus

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  // every field of the next state is computed here from the current state and the inputs
  always_comb
  begin
    logic       raw;
    logic       addr_ok;
    logic [3:0] ev;
    logic [3:0] clr;
    logic       pull;
    logic [1:0] code;
    raw     = 1'b0;
    addr_ok = 1'b0;
    ev      = 4'h0;
    clr     = 4'h0;
    pull    = 1'b0;
    code    = 2'h0;
    next_st = st;

    // sense source: vbus pin or bus-detect gpio
    raw = st.ctrl[CTRL_SENSE_SEL] ? vbus_sense_input : vbus_pin;
    // first flop only feeds the second
    next_st.vsync = {st.vsync[0], raw};
    // level must hold for the debounce time before it counts
    if (st.vsync[1] != st.vstable)
    begin
      if (st.deb_cnt == DEB_CYC - 6'h01)
      begin
        next_st.vstable = st.vsync[1];
        next_st.deb_cnt = 6'h00;
        ev[EV_ATTACH]   = st.vsync[1];
        ev[EV_DETACH]   = ~st.vsync[1];
      end
      else
      begin
        next_st.deb_cnt = st.deb_cnt + 6'h01;
      end
    end
    else
    begin
      next_st.deb_cnt = 6'h00;
    end

    // charger detection sequence
    next_st.pins.bcd_start = 1'b0;
    case (st.bcd)
      BCD_IDLE:
      begin
        if (st.vstable && st.ctrl[CTRL_BCD_EN])
        begin
          next_st.bcd            = BCD_DETECT;
          next_st.pins.bcd_start = 1'b1;
        end
      end
      BCD_DETECT:
      begin
        if (chg_done)
        begin
          next_st.bcd = BCD_DONE;
          next_st.chg = chg_type;
          ev[EV_CHG]  = 1'b1;
        end
      end
      BCD_DONE:
      begin
      end
      default:
      begin
        next_st.bcd = BCD_IDLE;
      end
    endcase
    // losing vbus drops the result at once
    if (!st.vstable)
    begin
      next_st.bcd = BCD_IDLE;
      next_st.chg = CHG_NONE;
    end

    // remote wakeup: rising edge of wake-up input while suspended
    next_st.wake_d                 = wakeup_in;
    next_st.pins.remote_wakeup_req = 1'b0;
    if (st.ctrl[CTRL_WAKE_EN] && usb.suspended && wakeup_in && !st.wake_d)
    begin
      next_st.pins.remote_wakeup_req = 1'b1;
      ev[EV_WAKE]                    = 1'b1;
    end

    // pull-up: with detection enabled a dedicated charger never sees the pull-up
    if (st.ctrl[CTRL_BCD_EN])
      pull = st.vstable && (st.chg == CHG_SDP || st.chg == CHG_CDP);
    else
      pull = st.vstable;
    next_st.pins.dplus_line = pull;

    // charger-type code through the configurable map
    if (!st.vstable || st.chg == CHG_NONE)
      code = st.map[MAP_UNCONF +: 2];
    else if (usb.suspended)
      code = st.map[MAP_SUSPEND +: 2];
    else if (st.chg == CHG_SDP)
      code = st.map[MAP_SDP +: 2];
    else
      code = st.map[MAP_CHARGE +: 2];
    next_st.pins.charger_type_bit0 = code[0];
    next_st.pins.charger_type_bit1 = code[1];

    // status pins
    next_st.pins.suspend_ind              = usb.suspended | ~usb.configured;
    next_st.pins.power_cut                = usb.suspended | ~usb.configured;
    next_st.pins.rx_activity_led_n        = ~usb.rx_active;
    next_st.pins.tx_activity_led_n        = ~usb.tx_active;
    next_st.pins.transceiver_drive_enable = uart_tx_pending;
    // pins leave high impedance only after reset is released
    next_st.pin_oe_n = 1'b0;

    // ahb data phase of a write
    next_st.wr_pend = 1'b0;
    if (st.wr_pend)
    begin
      case (st.wr_addr)
        ADDR_CTRL:  next_st.ctrl  = hwdata[2:0];
        ADDR_MAP:   next_st.map   = hwdata[7:0];
        ADDR_IST:   clr           = hwdata[3:0];
        ADDR_IMASK: next_st.imask = hwdata[3:0];
        default:    clr           = 4'h0;
      endcase
    end
    // a new event outranks a clear in the same cycle
    next_st.ist = (st.ist & ~clr) | ev;
    next_st.irq = |(next_st.ist & next_st.imask);

    // ahb address phase: read data is latched for the data phase
    addr_ok = hsel && htrans[1] && hready;
    if (addr_ok)
    begin
      next_st.wr_pend = hwrite;
      next_st.wr_addr = haddr;
      if (!hwrite)
      begin
        case (haddr)
          ADDR_CTRL:   next_st.hrdata = {29'h0, st.ctrl};
          ADDR_MAP:    next_st.hrdata = {24'h0, st.map};
          ADDR_STATUS: next_st.hrdata = {24'h0, usb.configured, usb.suspended,
                                         st.chg, st.pins.dplus_line, st.vstable,
                                         st.bcd};
          ADDR_IST:    next_st.hrdata = {28'h0, st.ist};
          ADDR_IMASK:  next_st.hrdata = {28'h0, st.imask};
          default:     next_st.hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  // reset holds every pin in high impedance and leds dark
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st                             <= '0;
      st.ctrl                        <= CTRL_RST;
      st.map                         <= MAP_RST;
      st.imask                       <= IMASK_RST;
      st.bcd                         <= BCD_IDLE;
      st.chg                         <= CHG_NONE;
      st.pins.rx_activity_led_n      <= 1'b1;
      st.pins.tx_activity_led_n      <= 1'b1;
      st.pins.suspend_ind            <= 1'b1;
      st.pins.power_cut              <= 1'b1;
      st.pin_oe_n                    <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // zero wait states, so hreadyout is tied high, not taken from a flop
  assign hrdata    = st.hrdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign pins      = st.pins;
  assign pin_oe_n  = st.pin_oe_n;
  assign irq       = st.irq;

endmodule

`default_nettype wire

/* File: tb/uacs_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// pin behaviour checks
// ----------------------------------------
module uacs_properties
  import uacs_pkg::*;
(
  // clock and reset
  input wire logic             hclk,
  input wire logic             hresetn,
  // watched inputs and outputs
  input wire logic             vbus_pin,
  input wire logic             vbus_sense_input,
  input wire uacs_pkg::uacs_usb_s  usb,
  input wire logic             uart_tx_pending,
  input wire logic             wakeup_in,
  input wire uacs_pkg::uacs_pins_s pins,
  input wire logic             pin_oe_n
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       up;
  logic [6:0] lo_n;
  logic [6:0] hi_n;
  // vbus run lengths on either sense path, saturating so long idles stay counted
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      up   <= 1'h0;
      lo_n <= 7'h00;
      hi_n <= 7'h00;
    end
    else
    begin
      up   <= 1'h1;
      lo_n <= (vbus_pin | vbus_sense_input) ? 7'h00 : lo_n + {6'h00, lo_n != 7'h7F};
      hi_n <= (vbus_pin | vbus_sense_input) ? hi_n + {6'h00, hi_n != 7'h7F} : 7'h00;
    end
  end
  sequence s_wake;
    up && usb.suspended && $rose(wakeup_in);
  endsequence
  property p_oe; up |-> !pin_oe_n; endproperty
  property p_susp; up |-> pins.suspend_ind == ($past(usb.suspended) || !$past(usb.configured)); endproperty
  property p_rx; up |-> pins.rx_activity_led_n == !$past(usb.rx_active); endproperty
  property p_tx; up |-> pins.tx_activity_led_n == !$past(usb.tx_active); endproperty
  property p_pcut; up |-> pins.power_cut == ($past(usb.suspended) || !$past(usb.configured)); endproperty
  property p_txen; up |-> pins.transceiver_drive_enable == $past(uart_tx_pending); endproperty
  property p_wake; s_wake |=> pins.remote_wakeup_req ##1 !pins.remote_wakeup_req; endproperty
  property p_gone; lo_n >= 7'h3C |-> !pins.dplus_line && !pins.charger_type_bit0 && !pins.charger_type_bit1;
  endproperty
  property p_deb; $rose(pins.dplus_line) |-> hi_n >= 7'h32; endproperty
  a_oe: assert property (p_oe)
    else $error("pins not driven after reset");
  a_susp: assert property (p_susp)
    else $error("suspend indicator wrong");
  a_rx: assert property (p_rx)
    else $error("rx led wrong");
  a_tx: assert property (p_tx)
    else $error("tx led wrong");
  a_pcut: assert property (p_pcut)
    else $error("power cut wrong");
  a_txen: assert property (p_txen)
    else $error("transceiver enable wrong");
  a_wake: assert property (p_wake)
    else $error("remote wakeup pulse missing");
  a_gone: assert property (p_gone)
    else $error("pull-up or code left after vbus loss");
  a_deb: assert property (p_deb)
    else $error("pull-up before vbus settled");
endmodule
bind uacs_top uacs_properties i_props (.hclk(hclk), .hresetn(hresetn), .vbus_pin(vbus_pin),
  .vbus_sense_input(vbus_sense_input), .usb(usb),
  .uart_tx_pending(uart_tx_pending), .wakeup_in(wakeup_in), .pins(pins), .pin_oe_n(pin_oe_n));
`default_nettype wire

/* File: tb/uacs_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host port and charger classifier
// ----------------------------------------
module uacs_host_model
  import uacs_pkg::*;
(
  // test control
  input  wire logic                hclk,
  input  wire logic                attach,
  input  wire uacs_pkg::uacs_chg_e kind,
  input  wire logic [3:0]          lat,
  input  wire logic                sense_only,
  // toward the device
  input  wire logic                bcd_start,
  output logic                     vbus_pin,
  output logic                     vbus_sense_input,
  output logic                     chg_done,
  output uacs_pkg::uacs_chg_e      chg_type
);
  logic [3:0] cnt = 4'h0;
  logic       busy = 1'h0;
  // sense_only: charger output absent, only the divider path sees vbus
  assign vbus_pin         = attach & ~sense_only;
  assign vbus_sense_input = attach; // divider output tracks vbus
  // answer lat+1 cycles after bcd_start is sampled; type is junk outside the done cycle
  always_ff @(posedge hclk)
  begin
    chg_done <= 1'h0;
    chg_type <= uacs_chg_e'(~kind);
    if (bcd_start)
    begin
      busy <= 1'h1;
      cnt  <= lat;
    end
    else if (busy && cnt == 4'h0)
    begin
      busy     <= 1'h0;
      chg_done <= 1'h1;
      chg_type <= kind;
    end
    else
      cnt <= cnt - 4'h1;
  end
endmodule
`default_nettype wire

/* File: tb/usb_attach_charger_status_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench
// ----------------------------------------
module usb_attach_charger_status_tb;
  import uacs_pkg::*;
  logic        hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, att = '0, wakeup_in = '0, uart_tx_pending = '0;
  logic        hreadyout, hresp, vbus_pin, vbus_sense_input, chg_done, pin_oe_n, irq;
  logic        split = '0;
  logic [7:0]  haddr = '0;
  logic [1:0]  htrans = '0;
  logic [3:0]  lat = '0;
  logic [31:0] hwdata = '0, hrdata, q;
  uacs_usb_s   usb = '0;
  uacs_chg_e   kind = CHG_SDP, chg_type;
  uacs_pins_s  pins;
  int          err_total = 0, samples_checked = 0;
  uacs_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .vbus_pin(vbus_pin), .vbus_sense_input(vbus_sense_input), .usb(usb),
    .chg_done(chg_done), .chg_type(chg_type), .uart_tx_pending(uart_tx_pending), .wakeup_in(wakeup_in),
    .pins(pins), .pin_oe_n(pin_oe_n), .irq(irq));
  uacs_host_model i_host (.hclk(hclk), .attach(att), .kind(kind), .lat(lat), .bcd_start(pins.bcd_start),
    .sense_only(split), .vbus_pin(vbus_pin), .vbus_sense_input(vbus_sense_input),
    .chg_done(chg_done), .chg_type(chg_type));
  initial
    forever #10 hclk = ~hclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    if (g !== e)
      err_total++;
  endtask
  // one single ahb transfer; waits on hready in both phases
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'h1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    q = hrdata;
  endtask
  // attach, read pull-up and code, detach, read again
  task automatic plug(input uacs_chg_e k, input logic [3:0] l, input logic [2:0] e);
    kind <= k;
    lat  <= l;
    att  <= 1'h1;
    repeat (90) @(posedge hclk);
    chk({pins.dplus_line, pins.charger_type_bit1, pins.charger_type_bit0}, e);
    att <= 1'h0;
    repeat (60) @(posedge hclk);
    chk({pins.dplus_line, pins.charger_type_bit1, pins.charger_type_bit0}, 3'h0);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge hclk);
    chk(pin_oe_n, 1'h1);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    chk(pin_oe_n, 1'h0);
    xfer(ADDR_CTRL, 1'h0, 32'h0);
    chk(q, 32'h5);
    xfer(ADDR_MAP, 1'h0, 32'h0);
    chk(q, 32'hE4);
    xfer(8'h3C, 1'h0, 32'h0);
    chk(q, 32'h0);
    chk(hresp, 1'h0);
    $display("test registers done");
    for (int i = 0; i < 32; i++)
    begin
      usb             <= i[3:0];
      uart_tx_pending <= i[4];
      repeat (2) @(posedge hclk);
      chk({pins.suspend_ind, pins.power_cut, pins.rx_activity_led_n, pins.tx_activity_led_n,
        pins.transceiver_drive_enable}, {{2{i[3] | !i[2]}}, !i[1], !i[0], i[4]});
    end
    $display("test usb state pins done");
    usb <= 4'h4;
    xfer(ADDR_IMASK, 1'h1, 32'h2);
    plug(CHG_SDP, 4'h0, 3'h5);
    plug(CHG_CDP, 4'h9, 3'h6);
    plug(CHG_DCP, 4'h3, 3'h2);
    chk(irq, 1'h1);
    xfer(ADDR_IST, 1'h0, 32'h0);
    chk(q, 32'h7);
    xfer(ADDR_IST, 1'h1, 32'h7);
    xfer(ADDR_IST, 1'h0, 32'h0);
    chk({q[3:0], irq}, 5'h0);
    usb <= 4'hC;
    plug(CHG_SDP, 4'h1, 3'h7);
    usb <= 4'h4;
    split <= 1'h1;
    xfer(ADDR_CTRL, 1'h1, 32'h6);
    plug(CHG_CDP, 4'h0, 3'h4);
    split <= 1'h0;
    xfer(ADDR_CTRL, 1'h1, 32'h5);
    att <= 1'h1;
    repeat (30) @(posedge hclk);
    chk(pins.dplus_line, 1'h0);
    att <= 1'h0;
    repeat (70) @(posedge hclk);
    chk(pins.dplus_line, 1'h0);
    $display("test charger detection done");
    for (int s = 0; s < 2; s++)
    begin
      usb <= s[0] ? 4'hC : 4'h4;
      repeat (2) @(posedge hclk);
      wakeup_in <= 1'h1;
      @(posedge hclk);
      @(negedge hclk);
      chk(pins.remote_wakeup_req, s[0]);
      @(posedge hclk);
      wakeup_in <= 1'h0;
    end
    xfer(ADDR_IST, 1'h0, 32'h0);
    chk(q[3], 1'h1);
    $display("test wakeup done");
    print_verdict();
  end
  // hang guard, far beyond the thousand or so cycles the tests need
  initial
  begin
    #400000;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
